//--- shared/mab_pkg.sv
package mab_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] MAB_OFS_INSTR = 8'h00;
  localparam logic [7:0] MAB_OFS_ACCUM = 8'h04;
  localparam logic [7:0] MAB_OFS_FLAGS = 8'h08;
  localparam logic [7:0] MAB_OFS_FADDR = 8'h0C;
  localparam logic [7:0] MAB_OFS_FDATA = 8'h10;

  // Widths of the datapath and of the file register space.
  localparam int MAB_DATA_W  = 8;
  localparam int MAB_ADDR_W  = 7;
  localparam int MAB_DEPTH   = 128;
  localparam int MAB_INSTR_W = 22;

  // Flag register bit positions.
  localparam int MAB_FLG_ZERO   = 0;
  localparam int MAB_FLG_DIGIT  = 1;
  localparam int MAB_FLG_CARRY  = 2;
  localparam int MAB_FLG_BUSY   = 3;

  // Values after reset.
  localparam logic [7:0]  MAB_ACCUM_RST = 8'h00;
  localparam logic [2:0]  MAB_FLAGS_RST = 3'h0;
  localparam logic [6:0]  MAB_FADDR_RST = 7'h00;
  localparam logic [21:0] MAB_INSTR_RST = 22'h000000;
  localparam logic [7:0]  MAB_FILE_RST  = 8'h00;

  // Instruction operation codes, encoded in order of declaration.
  typedef enum logic [2:0] {
    MAB_OP_ADD_REG_WITH_CARRY,
    MAB_OP_ADD_REG_TO_ACCUM,
    MAB_OP_ADD_LITERAL_WITH_CARRY,
    MAB_OP_ADD_LITERAL_TO_ACCUM,
    MAB_OP_AND_ACCUM_WITH_REG,
    MAB_OP_CLEAR_REG_BIT,
    MAB_OP_RSVD6,
    MAB_OP_RSVD7
  } mab_op_e;

  // Execution sequencer states.
  typedef enum logic {
    MAB_ST_IDLE,
    MAB_ST_EXEC
  } mab_state_e;

  // Instruction word as written to the instruction register.
  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic       dest;
    mab_op_e    op;
  } mab_instr_s;

  // Status flags carried together.
  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } mab_flags_s;

endpackage : mab_pkg

//--- design/mab_file_regs.sv
`timescale 1ns/100ps

// File register array: one write port, two combinational read ports.
module mab_file_regs
  import mab_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  wr_en_in,
  input  wire logic [MAB_ADDR_W-1:0] wr_addr_in,
  input  wire logic [MAB_DATA_W-1:0] wr_data_in,
  input  wire logic [MAB_ADDR_W-1:0] rd_addr_a_in,
  output logic      [MAB_DATA_W-1:0] rd_data_a_out,
  input  wire logic [MAB_ADDR_W-1:0] rd_addr_b_in,
  output logic      [MAB_DATA_W-1:0] rd_data_b_out
);

  logic [MAB_DATA_W-1:0] mem_reg  [MAB_DEPTH];
  logic [MAB_DATA_W-1:0] mem_next [MAB_DEPTH];

  // Next contents: only the addressed word changes on a write.
  always_comb begin
    for (int i = 0; i < MAB_DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en_in) begin
      mem_next[wr_addr_in] = wr_data_in;
    end
  end

  // Cleared at reset so reads never return unknown data.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < MAB_DEPTH; i++) begin
        mem_reg[i] <= MAB_FILE_RST;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rd_data_a_out = mem_reg[rd_addr_a_in];
  assign rd_data_b_out = mem_reg[rd_addr_b_in];

endmodule : mab_file_regs

//--- design/mab_alu.sv
`timescale 1ns/100ps

module mab_alu
  import mab_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [7:0]  accumulator_out,
  output logic             zero_flag_out,
  output logic             digit_carry_flag_out,
  output logic             carry_flag_out
);

  // Merge write data into an old register value by byte strobes.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // True when the offset names one of the implemented registers.
  function automatic logic addr_hit(input logic [7:0] addr);
    return (addr == MAB_OFS_INSTR) || (addr == MAB_OFS_ACCUM) ||
           (addr == MAB_OFS_FLAGS) || (addr == MAB_OFS_FADDR) ||
           (addr == MAB_OFS_FDATA);
  endfunction : addr_hit

  // Nine-bit adder with the carry out of bit 3 alongside.
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {low[4], sum};
  endfunction : add8

  // Architectural state.
  logic [7:0]            accum_reg;
  logic [7:0]            accum_next;
  mab_flags_s            flags_reg;
  mab_flags_s            flags_next;
  mab_instr_s            instr_reg;
  mab_instr_s            instr_next;
  mab_state_e            state_reg;
  mab_state_e            state_next;
  logic [MAB_ADDR_W-1:0] faddr_reg;
  logic [MAB_ADDR_W-1:0] faddr_next;

  // Bus answer state.
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // File register port wiring.
  logic                  file_we;
  logic [MAB_ADDR_W-1:0] file_waddr;
  logic [MAB_DATA_W-1:0] file_wdata;
  logic [MAB_DATA_W-1:0] exec_operand;
  logic [MAB_DATA_W-1:0] bus_operand;

  // Datapath intermediates.
  logic [9:0]  add_res;
  logic [7:0]  add_b;
  logic        add_cin;
  logic [7:0]  result;
  logic        bus_write;
  logic        bus_capture;
  logic [31:0] wr_merged;
  logic [31:0] instr_merged;

  mab_file_regs u_file_regs (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .wr_en_in      (file_we),
    .wr_addr_in    (file_waddr),
    .wr_data_in    (file_wdata),
    .rd_addr_a_in  (instr_reg.file_addr),
    .rd_data_a_out (exec_operand),
    .rd_addr_b_in  (faddr_reg),
    .rd_data_b_out (bus_operand)
  );

  // A write lands on the edge where the access phase sees pready high.
  assign bus_write = psel_in && penable_in && pready_reg && pwrite_in;

  // Answers are held back while an instruction executes, so a read never
  // samples the file register array in the same cycle that it changes.
  assign bus_capture = psel_in && !pready_reg && (state_reg == MAB_ST_IDLE);

  assign wr_merged = strb_merge(32'h00000000, pwdata_in, pstrb_in);
  assign instr_merged = strb_merge({10'h000, instr_reg}, pwdata_in,
                                   pstrb_in);

  // Operand selection for the shared adder.
  always_comb begin
    add_b   = exec_operand;
    add_cin = 1'b0;
    case (instr_reg.op)
      MAB_OP_ADD_REG_WITH_CARRY: begin
        add_cin = flags_reg.carry;
      end
      MAB_OP_ADD_REG_TO_ACCUM: begin
        add_cin = 1'b0;
      end
      MAB_OP_ADD_LITERAL_WITH_CARRY: begin
        add_b   = instr_reg.literal;
        add_cin = flags_reg.carry;
      end
      MAB_OP_ADD_LITERAL_TO_ACCUM: begin
        add_b   = instr_reg.literal;
        add_cin = 1'b0;
      end
      default: begin
        add_cin = 1'b0;
      end
    endcase
  end

  assign add_res = add8(accum_reg, add_b, add_cin);

  // Execution and register file updates. Execution takes the one cycle
  // after the instruction write; the bus cannot complete another write in
  // that cycle, so the two writers never collide.
  always_comb begin
    accum_next = accum_reg;
    flags_next = flags_reg;
    instr_next = instr_reg;
    faddr_next = faddr_reg;
    state_next = state_reg;
    file_we    = 1'b0;
    file_waddr = instr_reg.file_addr;
    file_wdata = 8'h00;
    result     = add_res[7:0];
    case (state_reg)
      MAB_ST_EXEC: begin
        state_next = MAB_ST_IDLE;
        case (instr_reg.op)
          MAB_OP_ADD_REG_WITH_CARRY,
          MAB_OP_ADD_REG_TO_ACCUM,
          MAB_OP_AND_ACCUM_WITH_REG: begin
            if (instr_reg.op == MAB_OP_AND_ACCUM_WITH_REG) begin
              result = accum_reg & exec_operand;
            end else begin
              flags_next.carry       = add_res[8];
              flags_next.digit_carry = add_res[9];
            end
            flags_next.zero = (result == 8'h00);
            if (instr_reg.dest) begin
              file_we    = 1'b1;
              file_wdata = result;
            end else begin
              accum_next = result;
            end
          end
          MAB_OP_ADD_LITERAL_WITH_CARRY,
          MAB_OP_ADD_LITERAL_TO_ACCUM: begin
            accum_next             = result;
            flags_next.carry       = add_res[8];
            flags_next.digit_carry = add_res[9];
            flags_next.zero        = (result == 8'h00);
          end
          MAB_OP_CLEAR_REG_BIT: begin
            result                   = exec_operand;
            result[instr_reg.bit_sel] = 1'b0;
            file_we                  = 1'b1;
            file_wdata               = result;
          end
          default: begin
            // Reserved codes execute as no operation.
            file_we = 1'b0;
          end
        endcase
      end
      MAB_ST_IDLE: begin
        if (bus_write && addr_hit(paddr_in)) begin
          case (paddr_in)
            MAB_OFS_INSTR: begin
              instr_next = instr_merged[MAB_INSTR_W-1:0];
              state_next = MAB_ST_EXEC;
            end
            MAB_OFS_ACCUM: begin
              if (pstrb_in[0]) begin
                accum_next = wr_merged[7:0];
              end
            end
            MAB_OFS_FLAGS: begin
              if (pstrb_in[0]) begin
                flags_next = {wr_merged[MAB_FLG_CARRY],
                              wr_merged[MAB_FLG_DIGIT],
                              wr_merged[MAB_FLG_ZERO]};
              end
            end
            MAB_OFS_FADDR: begin
              if (pstrb_in[0]) begin
                faddr_next = wr_merged[MAB_ADDR_W-1:0];
              end
            end
            MAB_OFS_FDATA: begin
              if (pstrb_in[0]) begin
                file_we    = 1'b1;
                file_waddr = faddr_reg;
                file_wdata = wr_merged[7:0];
              end
            end
            default: begin
              file_we = 1'b0;
            end
          endcase
        end
      end
      default: begin
        state_next = MAB_ST_IDLE;
      end
    endcase
  end

  // Bus answer: data and ready are registered one cycle after capture.
  always_comb begin
    prdata_next  = 32'h00000000;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (bus_capture) begin
      pready_next  = 1'b1;
      pslverr_next = !addr_hit(paddr_in);
      if (!pwrite_in) begin
        case (paddr_in)
          MAB_OFS_INSTR: prdata_next = {10'h000, instr_reg};
          MAB_OFS_ACCUM: prdata_next = {24'h000000, accum_reg};
          MAB_OFS_FLAGS: prdata_next = {28'h0000000, 1'b0,
                                        flags_reg.carry,
                                        flags_reg.digit_carry,
                                        flags_reg.zero};
          MAB_OFS_FADDR: prdata_next = {25'h0000000, faddr_reg};
          MAB_OFS_FDATA: prdata_next = {24'h000000, bus_operand};
          default:       prdata_next = 32'h00000000;
        endcase
      end
    end
  end

  // Register all state; outputs come straight from these flops.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accum_reg   <= MAB_ACCUM_RST;
      flags_reg   <= MAB_FLAGS_RST;
      instr_reg   <= MAB_INSTR_RST;
      faddr_reg   <= MAB_FADDR_RST;
      state_reg   <= MAB_ST_IDLE;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      accum_reg   <= accum_next;
      flags_reg   <= flags_next;
      instr_reg   <= instr_next;
      faddr_reg   <= faddr_next;
      state_reg   <= state_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_out           = prdata_reg;
  assign pready_out           = pready_reg;
  assign pslverr_out          = pslverr_reg;
  assign accumulator_out      = accum_reg;
  assign zero_flag_out        = flags_reg.zero;
  assign digit_carry_flag_out = flags_reg.digit_carry;
  assign carry_flag_out       = flags_reg.carry;

endmodule : mab_alu

//--- dv/mab_alu_properties.sv
`timescale 1ns/100ps

// Watches the bus, models the result of each literal add, checks the zero flag of ops 0, 1 and 4 to the accumulator and side effects of ops 0, 1, 4 and 5.
module mab_alu_chk
  import mab_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [7:0]  accumulator_out,
  input wire logic        zero_flag_out,
  input wire logic        digit_carry_flag_out,
  input wire logic        carry_flag_out
);
  logic [21:0] ins_q;
  logic [7:0]  acc_q;
  logic [2:0]  fl_q;
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic        cin;
  logic        w0;
  logic [2:0]  op;

  // An instruction word completes its write on this edge.
  assign w0 = psel_in && penable_in && pready_out && pwrite_in &&
              (paddr_in == MAB_OFS_INSTR);
  assign op = pwdata_in[2:0];

  // Operands are frozen at the write, since execution follows a cycle later.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ins_q <= 22'h0;
      acc_q <= 8'h00;
      fl_q  <= 3'h0;
    end else if (w0) begin
      ins_q <= pwdata_in[21:0];
      acc_q <= accumulator_out;
      fl_q  <= {carry_flag_out, digit_carry_flag_out, zero_flag_out};
    end
  end

  // The carry enters only the with-carry literal form.
  always_comb begin
    cin = (ins_q[2:0] == 3'h2) & fl_q[2];
    sum = {1'h0, acc_q} + {1'h0, ins_q[21:14]} + {8'h00, cin};
    nib = {1'h0, acc_q[3:0]} + {1'h0, ins_q[17:14]} + {4'h0, cin};
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  lit_add_a: assert property (w0 && op == 3'h3 |-> ##2
    accumulator_out == sum[7:0]) else $error("literal add wrong");
  lit_adc_a: assert property (w0 && op == 3'h2 |-> ##2
    accumulator_out == sum[7:0]) else $error("literal add carry wrong");
  carry_out_a: assert property (w0 && op[2:1] == 2'h1 |-> ##2
    carry_flag_out == sum[8]) else $error("carry flag wrong");
  digit_out_a: assert property (w0 && op[2:1] == 2'h1 |-> ##2
    digit_carry_flag_out == nib[4]) else $error("digit carry wrong");
  zero_res_a: assert property (w0 && op < 3'h5 &&
    (!pwdata_in[3] || op[2:1] == 2'h1) |-> ##2
    zero_flag_out == (accumulator_out == 8'h00)) else $error("zero wrong");
  and_keep_a: assert property (w0 && op == 3'h4 |-> ##2
    {carry_flag_out, digit_carry_flag_out} == fl_q[2:1])
    else $error("and changed carry");
  clear_keep_a: assert property (w0 && op == 3'h5 |=> (
    {carry_flag_out, digit_carry_flag_out, zero_flag_out} == fl_q &&
    accumulator_out == acc_q) [*2]) else $error("bit clear side effect");
  dest_reg_a: assert property (w0 && pwdata_in[3] &&
    (op < 3'h2 || op == 3'h4) |=> (accumulator_out == acc_q) [*2])
    else $error("accumulator written for register destination");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");

  cover property (w0 && op == 3'h2);
  cover property (w0 && op == 3'h5);
  cover property (pslverr_out);
endmodule : mab_alu_chk

bind mab_alu mab_alu_chk i_chk (.clk_in, .rst_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out,
  .accumulator_out, .zero_flag_out, .digit_carry_flag_out, .carry_flag_out);

//--- dv/testbench.sv
`timescale 1ns/100ps

// For each of the 13 rows, loads operands over the bus, runs one instruction, reads results back.
module testbench
  import mab_pkg::*;
;
  typedef struct packed {
    logic [2:0] op;
    logic       d;
    logic [2:0] b;
    logic [6:0] fa;
    logic [7:0] lit, acc;
    logic [2:0] fl;
    logic [7:0] r, eacc, er;
    logic [2:0] efl;
  } mab_row_s;

  logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic        zf, dcf, cf;
  logic [7:0]  paddr, acc_o;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  int          bad_count, cmp_count;
  // Fields: op, dest, bit, file address, literal, acc, flags, reg, results.
  // The last row carries a reserved code, which must leave the accumulator, flags and file alone.
  mab_row_s    rows [13] = '{
    '{3'h0,1'h1,3'h0,7'h05,8'h00,8'h12,3'h4,8'h34,8'h12,8'h47,3'h0},
    '{3'h1,1'h1,3'h0,7'h05,8'h00,8'h12,3'h4,8'h34,8'h12,8'h46,3'h0},
    '{3'h2,1'h0,3'h0,7'h10,8'h34,8'h12,3'h4,8'h55,8'h47,8'h55,3'h0},
    '{3'h3,1'h0,3'h0,7'h10,8'h34,8'h12,3'h4,8'h55,8'h46,8'h55,3'h0},
    '{3'h4,1'h1,3'h0,7'h20,8'h00,8'h5A,3'h6,8'hAF,8'h5A,8'h0A,3'h6},
    '{3'h5,1'h0,3'h3,7'h20,8'h00,8'h12,3'h7,8'h5A,8'h12,8'h52,3'h7},
    '{3'h1,1'h0,3'h0,7'h7F,8'h00,8'hFF,3'h0,8'h01,8'h00,8'h01,3'h7},
    '{3'h0,1'h0,3'h0,7'h00,8'h00,8'h0F,3'h4,8'h00,8'h10,8'h00,3'h2},
    '{3'h4,1'h0,3'h0,7'h40,8'h00,8'hF0,3'h6,8'h0F,8'h00,8'h0F,3'h7},
    '{3'h5,1'h1,3'h7,7'h7F,8'h00,8'h33,3'h0,8'h80,8'h33,8'h00,3'h0},
    '{3'h2,1'h0,3'h0,7'h01,8'h00,8'hFF,3'h4,8'h99,8'h00,8'h99,3'h7},
    '{3'h3,1'h0,3'h0,7'h01,8'hFF,8'h01,3'h4,8'h99,8'h00,8'h99,3'h7},
    '{3'h6,1'h1,3'h2,7'h05,8'h77,8'h12,3'h5,8'h34,8'h12,8'h34,3'h5}};

  mab_alu i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .accumulator_out(acc_o),
    .zero_flag_out(zf), .digit_carry_flag_out(dcf), .carry_flag_out(cf));

  // Free running clock, 100 ns period.
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; the first edge keeps it apart from the previous one.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk_in);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= {4{w}};
    @(posedge clk_in);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  initial begin
    logic [31:0] r;
    logic        e;
    mab_instr_s  ins;
    {rst_n_in, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'h1;
    foreach (rows[i]) begin
      ins = '{rows[i].lit, rows[i].fa, rows[i].b, rows[i].d,
              mab_op_e'(rows[i].op)};
      apb(1'h1, MAB_OFS_ACCUM, {24'h0, rows[i].acc}, r, e);
      apb(1'h1, MAB_OFS_FLAGS, {29'h0, rows[i].fl}, r, e);
      apb(1'h1, MAB_OFS_FADDR, {25'h0, rows[i].fa}, r, e);
      apb(1'h1, MAB_OFS_FDATA, {24'h0, rows[i].r}, r, e);
      apb(1'h1, MAB_OFS_INSTR, {10'h0, ins}, r, e);
      apb(1'h0, MAB_OFS_ACCUM, 32'h0, r, e);
      chk(r, {24'h0, rows[i].eacc});
      chk({21'h0, acc_o, cf, dcf, zf},
          {21'h0, rows[i].eacc, rows[i].efl});
      apb(1'h0, MAB_OFS_FLAGS, 32'h0, r, e);
      chk(r, {29'h0, rows[i].efl});
      apb(1'h0, MAB_OFS_FDATA, 32'h0, r, e);
      chk(r, {24'h0, rows[i].er});
      $display("row %0d done", i);
    end
    // An unmapped place answers with an error and reads as zero.
    apb(1'h0, 8'h14, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    chk(r, 32'h0);
    $display("bus error test done");
    // A reset in mid run clears the accumulator, flags, address and file.
    // Non-zero values are loaded first so that a missed clear shows up.
    apb(1'h1, MAB_OFS_ACCUM, 32'h000000A5, r, e);
    @(posedge clk_in);
    rst_n_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'h1;
    chk({21'h0, acc_o, cf, dcf, zf}, 32'h0);
    apb(1'h0, MAB_OFS_FLAGS, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'h0, MAB_OFS_FADDR, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'h1, MAB_OFS_FADDR, 32'h00000001, r, e);
    apb(1'h0, MAB_OFS_FDATA, 32'h0, r, e);
    chk(r, 32'h0);
    $display("reset test done");
    results();
  end
endmodule : testbench
